// *** rtl/fbo_cfg.svh ***
/*
 Constants for the parallel flash bus host controller: pin field positions,
 address widths, sector protect address bits and bus cycle timing counts.
 Assumes a 20 MHz mclk and an includer that uses these names only.
*/
`ifndef FBO_CFG_SVH
`define FBO_CFG_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define FBO_CLK_MHZ        20
`define FBO_ACC_NS         120
`define FBO_ACC_CYC        (((`FBO_ACC_NS) * (`FBO_CLK_MHZ) + 999) / 1000)
`define FBO_WP_NS          50
`define FBO_WP_CYC         (((`FBO_WP_NS) * (`FBO_CLK_MHZ) + 999) / 1000)
`define FBO_RP_NS          500
`define FBO_RP_CYC         (((`FBO_RP_NS) * (`FBO_CLK_MHZ) + 999) / 1000)
`define FBO_RH_NS          50
`define FBO_RH_CYC         (((`FBO_RH_NS) * (`FBO_CLK_MHZ) + 999) / 1000)
`define FBO_CNT_W          8

// ****************************************************************
// Address and data layout
// ****************************************************************
`define FBO_WADDR_W        20
`define FBO_BADDR_W        21
`define FBO_DATA_W         16
`define FBO_LANE_W         8
`define FBO_DQ15_BIT       15
`define FBO_A6_BIT         6
`define FBO_A1_BIT         1
`define FBO_A0_BIT         0

`endif

// *** rtl/fbo_host.sv ***
/*
 Host controller for an asynchronous parallel flash: runs read, write,
 sector protect, sector unprotect and hardware reset cycles on the pins.
 Assumes a user that holds a request until it sees req_ready high.
*/
// Contract
// - Read cycle drives chip select and output gate low, write strobe high.
// - Command write drives write strobe and chip select low, output gate high.
// - In unlock-bypass mode host issues two program cycles, not four; host has no bypass mode and issues one write strobe per request.
// - Sector protect: elevated ID level, writes with A6 low, A1 high, A0 low.
// - Sector unprotect: same controls, A6 high, A1 high, A0 low.
`timescale 1ns/10ps
`include "fbo_cfg.svh"
module fbo_host
   import fbo_pkg::*;
(
   input  wire logic                     mclk,
   input  wire logic                     rst_n,
   input  wire logic                     req_valid,
   input  wire logic [2:0]               req_op,
   input  wire logic [`FBO_BADDR_W-1:0]  req_addr,
   input  wire logic [`FBO_DATA_W-1:0]   req_wdata,
   input  wire logic                     req_byte_mode,
   output logic                          req_ready,
   output logic                          rsp_valid,
   output logic [`FBO_DATA_W-1:0]        rsp_rdata,
   output logic                          dev_ready,
   output logic                          ce_n,
   output logic                          oe_n,
   output logic                          we_n,
   output logic                          reset_n,
   output logic                          elevated_id_level,
   output logic                          byte_n,
   output logic [`FBO_WADDR_W-1:0]       addr,
   output logic [`FBO_DATA_W-1:0]        dq_out,
   output logic [`FBO_DATA_W-1:0]        dq_oe,
   input  wire logic [`FBO_DATA_W-1:0]   dq_in,
   input  wire logic                     ready_busy_n
);

   fbo_pins_if  pins ();
   fbo_ctl_type ctl_r;
   fbo_ctl_type ctl_nxt;
   logic [`FBO_DATA_W-1:0] dq_s1_r;
   logic [`FBO_DATA_W-1:0] dq_s2_r;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic is_prot_op(input fbo_op_type op);
      is_prot_op = (op == FBO_OP_PROTECT) || (op == FBO_OP_UNPROT);
   endfunction : is_prot_op

   function automatic logic is_write_op(input fbo_op_type op);
      is_write_op = (op == FBO_OP_WRITE) || is_prot_op(op);
   endfunction : is_write_op

   // Pins A6, A1, A0 sit one bit higher in a byte address
   function automatic logic [`FBO_BADDR_W-1:0] prot_addr(input logic [`FBO_BADDR_W-1:0] a,
                                                         input logic                     bm,
                                                         input logic                     a6);
      prot_addr = a;
      if (bm)
      begin
         prot_addr[`FBO_A6_BIT+1] = a6;
         prot_addr[`FBO_A1_BIT+1] = 1'b1;
         prot_addr[`FBO_A0_BIT+1] = 1'b0;
      end
      else
      begin
         prot_addr[`FBO_A6_BIT] = a6;
         prot_addr[`FBO_A1_BIT] = 1'b1;
         prot_addr[`FBO_A0_BIT] = 1'b0;
      end
   endfunction : prot_addr

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_comb
   begin
      ctl_nxt        = ctl_r;
      ctl_nxt.done   = 1'b0;
      ctl_nxt.rdy_s1 = ready_busy_n;
      ctl_nxt.rdy_s2 = ctl_r.rdy_s1;
      case (ctl_r.st)
         FBO_ST_IDLE:
         begin
            ctl_nxt.busy = 1'b0;
            if (req_valid)
            begin
               ctl_nxt.op        = fbo_op_type'(req_op);
               ctl_nxt.addr      = req_addr;
               ctl_nxt.wdata     = req_wdata;
               ctl_nxt.byte_mode = req_byte_mode;
               ctl_nxt.busy      = 1'b1;
               ctl_nxt.cnt       = '0;
               if (fbo_op_type'(req_op) == FBO_OP_RESET)
               begin
                  ctl_nxt.st = FBO_ST_RESET;
               end
               else
               begin
                  ctl_nxt.st = FBO_ST_SETUP;
               end
               if (fbo_op_type'(req_op) == FBO_OP_PROTECT)
               begin
                  ctl_nxt.addr = prot_addr(req_addr, req_byte_mode, 1'b0);
               end
               else if (fbo_op_type'(req_op) == FBO_OP_UNPROT)
               begin
                  ctl_nxt.addr = prot_addr(req_addr, req_byte_mode, 1'b1);
               end
            end
         end
         FBO_ST_SETUP:
         begin
            ctl_nxt.st  = FBO_ST_STROBE;
            ctl_nxt.cnt = '0;
         end
         FBO_ST_STROBE:
         begin
            ctl_nxt.cnt = ctl_r.cnt + 1'b1;
            if (is_write_op(ctl_r.op))
            begin
               if (ctl_r.cnt == `FBO_CNT_W'(`FBO_WP_CYC - 1))
               begin
                  ctl_nxt.st = FBO_ST_HOLD;
               end
            end
            else if (ctl_r.cnt == `FBO_CNT_W'(`FBO_ACC_CYC + 1))
            begin
               // Two extra cycles cover the data synchroniser
               ctl_nxt.rdata = dq_s2_r;
               if (ctl_r.byte_mode)
               begin
                  ctl_nxt.rdata[`FBO_DATA_W-1:`FBO_LANE_W] = '0;
               end
               ctl_nxt.st = FBO_ST_HOLD;
            end
         end
         FBO_ST_HOLD:
         begin
            ctl_nxt.st   = FBO_ST_IDLE;
            ctl_nxt.done = 1'b1;
            ctl_nxt.busy = 1'b0;
         end
         FBO_ST_RESET:
         begin
            ctl_nxt.cnt = ctl_r.cnt + 1'b1;
            if (ctl_r.cnt == `FBO_CNT_W'(`FBO_RP_CYC - 1))
            begin
               ctl_nxt.st  = FBO_ST_RECOV;
               ctl_nxt.cnt = '0;
            end
         end
         FBO_ST_RECOV:
         begin
            ctl_nxt.cnt = ctl_r.cnt + 1'b1;
            if (ctl_r.cnt >= `FBO_CNT_W'(`FBO_RH_CYC - 1) && ctl_r.rdy_s2)
            begin
               ctl_nxt.st   = FBO_ST_IDLE;
               ctl_nxt.done = 1'b1;
               ctl_nxt.busy = 1'b0;
            end
         end
         default:
         begin
            ctl_nxt.st = FBO_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctl_r    <= '0;
         ctl_r.st <= FBO_ST_IDLE;
         dq_s1_r  <= '0;
         dq_s2_r  <= '0;
      end
      else
      begin
         ctl_r   <= ctl_nxt;
         dq_s1_r <= dq_in;
         dq_s2_r <= dq_s1_r;
      end
   end

   // ****************************************************************
   // Pin bundle
   // ****************************************************************
   always_comb
   begin
      // Idle is standby: chip select high, outputs left to float except DQ15 in byte mode
      pins.ce_n              = 1'b1;
      pins.oe_n              = 1'b1;
      pins.we_n              = 1'b1;
      pins.reset_n           = 1'b1;
      pins.elevated_id_level = 1'b0;
      pins.drive             = 1'b0;
      pins.byte_mode         = ctl_r.byte_mode;
      pins.addr              = ctl_r.addr;
      pins.wdata             = ctl_r.wdata;
      if (ctl_r.st == FBO_ST_RESET)
      begin
         pins.reset_n = 1'b0;
      end
      else if (ctl_r.st != FBO_ST_IDLE && ctl_r.st != FBO_ST_RECOV)
      begin
         pins.ce_n = 1'b0;
         if (is_write_op(ctl_r.op))
         begin
            // Commands reach the device latches only through write strobes
            pins.drive             = 1'b1;
            // One strobe per request: bypass programs take two requests
            pins.we_n              = (ctl_r.st != FBO_ST_STROBE);
            pins.elevated_id_level = is_prot_op(ctl_r.op);
         end
         else
         begin
            pins.oe_n = (ctl_r.st == FBO_ST_SETUP);
         end
      end
   end

   fbo_pin_drv u_drv
   (
      .mclk              (mclk),
      .rst_n             (rst_n),
      .pins              (pins),
      .ce_n              (ce_n),
      .oe_n              (oe_n),
      .we_n              (we_n),
      .reset_n           (reset_n),
      .elevated_id_level (elevated_id_level),
      .byte_n            (byte_n),
      .addr              (addr),
      .dq_out            (dq_out),
      .dq_oe             (dq_oe)
   );

   assign req_ready = ~ctl_r.busy;
   assign rsp_valid = ctl_r.done;
   assign rsp_rdata = ctl_r.rdata;
   assign dev_ready = ctl_r.rdy_s2;

endmodule : fbo_host

// *** rtl/fbo_pin_drv.sv ***
/*
 Registers the flash pins from the sequencer bundle and maps the byte or
 word address onto the address pins and the shared top data pin.
 Assumes a sequencer on the same clock that never drives during reads.
*/
`timescale 1ns/10ps
`include "fbo_cfg.svh"
module fbo_pin_drv
   import fbo_pkg::*;
(
   input  wire logic                     mclk,
   input  wire logic                     rst_n,
   fbo_pins_if.drv                       pins,
   output logic                          ce_n,
   output logic                          oe_n,
   output logic                          we_n,
   output logic                          reset_n,
   output logic                          elevated_id_level,
   output logic                          byte_n,
   output logic [`FBO_WADDR_W-1:0]       addr,
   output logic [`FBO_DATA_W-1:0]        dq_out,
   output logic [`FBO_DATA_W-1:0]        dq_oe
);

   typedef struct packed
   {
      logic                     ce_n;
      logic                     oe_n;
      logic                     we_n;
      logic                     reset_n;
      logic                     vid;
      logic                     byte_n;
      logic [`FBO_WADDR_W-1:0]  addr;
      logic [`FBO_DATA_W-1:0]   dq_out;
      logic [`FBO_DATA_W-1:0]   dq_oe;
   } fbo_drv_type;

   fbo_drv_type drv_r;
   fbo_drv_type drv_nxt;

   // ****************************************************************
   // Pin mapping
   // ****************************************************************
   always_comb
   begin
      drv_nxt         = drv_r;
      drv_nxt.ce_n    = pins.ce_n;
      drv_nxt.oe_n    = pins.oe_n;
      drv_nxt.we_n    = pins.we_n;
      drv_nxt.reset_n = pins.reset_n;
      drv_nxt.vid     = pins.elevated_id_level;
      drv_nxt.byte_n  = ~pins.byte_mode;
      drv_nxt.dq_oe   = '0;
      drv_nxt.dq_out  = '0;
      if (pins.byte_mode)
      begin
         // Byte address: top data pin carries the lowest address bit
         drv_nxt.addr                  = pins.addr[`FBO_BADDR_W-1:1];
         drv_nxt.dq_out[`FBO_DQ15_BIT] = pins.addr[0];
         drv_nxt.dq_oe[`FBO_DQ15_BIT]  = 1'b1;
         if (pins.drive)
         begin
            drv_nxt.dq_out[`FBO_LANE_W-1:0] = pins.wdata[`FBO_LANE_W-1:0];
            drv_nxt.dq_oe[`FBO_LANE_W-1:0]  = '1;
         end
      end
      else
      begin
         drv_nxt.addr = pins.addr[`FBO_WADDR_W-1:0];
         if (pins.drive)
         begin
            drv_nxt.dq_out = pins.wdata;
            drv_nxt.dq_oe  = '1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         drv_r         <= '0;
         drv_r.ce_n    <= 1'b1;
         drv_r.oe_n    <= 1'b1;
         drv_r.we_n    <= 1'b1;
         drv_r.byte_n  <= 1'b1;
      end
      else
      begin
         drv_r <= drv_nxt;
      end
   end

   assign ce_n              = drv_r.ce_n;
   assign oe_n              = drv_r.oe_n;
   assign we_n              = drv_r.we_n;
   assign reset_n           = drv_r.reset_n;
   assign elevated_id_level = drv_r.vid;
   assign byte_n            = drv_r.byte_n;
   assign addr              = drv_r.addr;
   assign dq_out            = drv_r.dq_out;
   assign dq_oe             = drv_r.dq_oe;

endmodule : fbo_pin_drv

// *** rtl/fbo_pins_if.sv ***
/*
 Interface carrying the flash pin drive bundle from the sequencer to the
 pin driver. Assumes both ends run on the same mclk.
*/
`timescale 1ns/10ps
`include "fbo_cfg.svh"
interface fbo_pins_if;
   logic                     ce_n;
   logic                     oe_n;
   logic                     we_n;
   logic                     reset_n;
   logic                     elevated_id_level;
   logic                     byte_mode;
   logic                     drive;
   logic [`FBO_BADDR_W-1:0]  addr;
   logic [`FBO_DATA_W-1:0]   wdata;
   modport seq (output ce_n, oe_n, we_n, reset_n, elevated_id_level,
                byte_mode, drive, addr, wdata);
   modport drv (input ce_n, oe_n, we_n, reset_n, elevated_id_level,
                byte_mode, drive, addr, wdata);
endinterface : fbo_pins_if

// *** rtl/fbo_pkg.sv ***
/*
 Types for the parallel flash bus host controller.
 Assumes fbo_cfg.svh is on the include path.
*/
`include "fbo_cfg.svh"
package fbo_pkg;

   typedef enum logic [2:0]
   {
      FBO_OP_READ    = 3'h0,
      FBO_OP_WRITE   = 3'h1,
      FBO_OP_PROTECT = 3'h2,
      FBO_OP_UNPROT  = 3'h3,
      FBO_OP_RESET   = 3'h4
   } fbo_op_type;

   typedef enum logic [5:0]
   {
      FBO_ST_IDLE   = 6'b00_0001,
      FBO_ST_SETUP  = 6'b00_0010,
      FBO_ST_STROBE = 6'b00_0100,
      FBO_ST_HOLD   = 6'b00_1000,
      FBO_ST_RESET  = 6'b01_0000,
      FBO_ST_RECOV  = 6'b10_0000
   } fbo_state_type;

   typedef struct packed
   {
      fbo_state_type              st;
      fbo_op_type                 op;
      logic [`FBO_CNT_W-1:0]      cnt;
      logic [`FBO_BADDR_W-1:0]    addr;
      logic [`FBO_DATA_W-1:0]     wdata;
      logic                       byte_mode;
      logic [`FBO_DATA_W-1:0]     rdata;
      logic                       done;
      logic                       busy;
      logic                       rdy_s1;
      logic                       rdy_s2;
   } fbo_ctl_type;

endpackage : fbo_pkg

// *** tb/fbo_flash_model.sv ***
/*
 Behavioural flash device on the far side of fbo_host: array reads,
 command latches filled by write cycles, and a hardware reset pin.
 Assumes the testbench resolves the shared data lines.
*/
`timescale 1ns/10ps
module fbo_flash_model
   import fbo_pkg::*;
#(
   parameter int ACC_NS = 60,
   parameter int RDY_NS = 100
)
(
   input  wire logic          ce_n,
   input  wire logic          oe_n,
   input  wire logic          we_n,
   input  wire logic          reset_n,
   input  wire logic          elevated_id_level,
   input  wire logic          byte_n,
   input  wire logic [19:0]   addr,
   input  wire logic [15:0]   dq,
   output logic [15:0]        dq_out,
   output logic [15:0]        dq_oe,
   output logic               ready_busy_n
);
   logic [20:0]   cmd_addr = 21'h00_0000;
   logic [15:0]   cmd_data = 16'h0000;
   logic          cmd_prot = 1'b0;
   logic          mode_cmd = 1'b0;
   logic [15:0]   word;
   logic [15:0]   oe_v;

   function automatic logic [15:0] arr_word(input logic [19:0] wa);
      return {wa[7:0] ^ wa[19:12], wa[15:8] ^ 8'hC3};
   endfunction : arr_word

   // Array data only; the command latches have no read path
   always_comb
   begin
      word = arr_word(addr);
      dq_out = byte_n ? word : {8'h00, dq[15] ? word[15:8] : word[7:0]};
      oe_v = 16'h0000;
      if (!ce_n && !oe_n && we_n && reset_n)
         oe_v = byte_n ? 16'hFFFF : 16'h00FF;
   end
   assign #(ACC_NS) dq_oe = oe_v;

   always @(posedge we_n)
   begin
      if (!ce_n && oe_n && reset_n)
      begin
         cmd_addr = byte_n ? {1'b0, addr} : {addr, dq[15]};
         cmd_data = byte_n ? dq : {8'h00, dq[7:0]};
         cmd_prot = elevated_id_level;
         mode_cmd = 1'b1;
      end
   end

   initial ready_busy_n = 1'b1;
   always @(reset_n)
   begin
      if (reset_n === 1'b0)
      begin
         mode_cmd = 1'b0;
         ready_busy_n = 1'b0;
      end
      else
         ready_busy_n <= #(RDY_NS) 1'b1;
   end
endmodule : fbo_flash_model

// *** tb/fbo_host_props.sv ***
/*
 Concurrent checks on the pins and request handshake of fbo_host.
 Assumes the bind below and the timing counts chosen in fbo_cfg.svh.
*/
`timescale 1ns/10ps
module fbo_host_props
   import fbo_pkg::*;
(
   input wire logic          mclk,
   input wire logic          rst_n,
   input wire logic          req_valid,
   input wire logic          req_ready,
   input wire logic [2:0]    req_op,
   input wire logic          rsp_valid,
   input wire logic          ce_n,
   input wire logic          oe_n,
   input wire logic          we_n,
   input wire logic          reset_n,
   input wire logic          elevated_id_level,
   input wire logic          byte_n,
   input wire logic [19:0]   addr,
   input wire logic [15:0]   dq_out,
   input wire logic [15:0]   dq_oe
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence take_s(op);
      req_valid && req_ready && req_op == op;
   endsequence

   sequence rst_pulse_s;
      !reset_n [*8] ##1 !reset_n ##1 !reset_n ##1 reset_n;
   endsequence

   chk_read_levels: assert property (!oe_n |-> !ce_n && we_n && reset_n)
      else $error("read cycle with wrong control levels");
   chk_write_levels: assert property (!we_n |-> !ce_n && oe_n)
      else $error("write cycle with wrong control levels");
   chk_read_float: assert property (!oe_n |-> dq_oe[14:0] == 15'h0 && dq_oe[15] == !byte_n)
      else $error("host drives data during a read");
   chk_lsb_drive: assert property (!ce_n && !byte_n |-> dq_oe[15])
      else $error("byte address bit not driven in byte mode");
   chk_read_answer: assert property (take_s(3'h0) |-> ##3 !oe_n ##5 rsp_valid)
      else $error("read cycle timing wrong");
   chk_write_pulse: assert property (take_s(3'h1) |-> ##3 !we_n ##1 (we_n && rsp_valid))
      else $error("write strobe timing wrong");
   chk_write_stable: assert property (!we_n |-> $stable(dq_out) && $stable(addr))
      else $error("address or data moved under write strobe");
   chk_reset_width: assert property ($fell(reset_n) |-> rst_pulse_s)
      else $error("reset pulse is not ten cycles");
   chk_protect_addr: assert property (!we_n && elevated_id_level |-> addr[1] && !addr[0])
      else $error("protect address bits wrong");
endmodule : fbo_host_props

bind fbo_host fbo_host_props u_fbo_host_props (.mclk, .rst_n, .req_valid, .req_ready, .req_op,
   .rsp_valid, .ce_n, .oe_n, .we_n, .reset_n, .elevated_id_level, .byte_n, .addr, .dq_out, .dq_oe);

// *** tb/test_fbo_host.sv ***
/*
 Self-checking testbench for fbo_host against the flash model.
 Assumes a 50 ns mclk and the hand-over timing of the host controller.
*/
`timescale 1ns/10ps
module test_fbo_host;
   import fbo_pkg::*;
   typedef struct {logic [2:0] op; logic bm; logic [20:0] a; logic [15:0] d;
                   logic [20:0] ea; logic [15:0] ed;} fbo_row_type;
   logic mclk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_byte_mode = 1'b0;
   logic [2:0] req_op = 3'h0;
   logic [20:0] req_addr = 21'h00_0000;
   logic [15:0] req_wdata = 16'h0000, flt = 16'h0F0F, dq_bus, m_out, m_oe, w, ed;
   logic req_ready, rsp_valid, dev_ready, ce_n, oe_n, we_n, reset_n, elevated_id_level, byte_n;
   logic ready_busy_n;
   logic [19:0] addr;
   logic [15:0] rsp_rdata, dq_out, dq_oe;
   int miscompares = 0, n_checks = 0;
   fbo_row_type r;
   fbo_row_type rows[8] = '{
      '{3'h0, 1'b0, 21'h10_1234, 16'h0000, 21'h00_0000, 16'h0000},
      '{3'h0, 1'b1, 21'h01_2345, 16'h0000, 21'h00_0000, 16'h0000},
      '{3'h0, 1'b1, 21'h00_2344, 16'h0000, 21'h00_0000, 16'h0000},
      '{3'h1, 1'b0, 21'h00_0555, 16'h00AA, 21'h00_0555, 16'h00AA},
      '{3'h1, 1'b1, 21'h00_0AAA, 16'hBE55, 21'h00_0AAA, 16'h0055},
      '{3'h2, 1'b0, 21'h00_A0FF, 16'h0000, 21'h00_A0BE, 16'h0000},
      '{3'h3, 1'b0, 21'h00_A000, 16'h0000, 21'h00_A042, 16'h0000},
      '{3'h1, 1'b0, 21'h11_F000, 16'h0030, 21'h01_F000, 16'h0030}};

   fbo_host u_fbo_host (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_byte_mode(req_byte_mode),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .dev_ready(dev_ready),
      .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(reset_n),
      .elevated_id_level(elevated_id_level), .byte_n(byte_n), .addr(addr), .dq_out(dq_out),
      .dq_oe(dq_oe), .dq_in(dq_bus), .ready_busy_n(ready_busy_n));
   fbo_flash_model u_fbo_flash_model (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(reset_n),
      .elevated_id_level(elevated_id_level), .byte_n(byte_n), .addr(addr), .dq(dq_bus),
      .dq_out(m_out), .dq_oe(m_oe), .ready_busy_n(ready_busy_n));

   // Released lines show a pattern that changes every cycle
   assign dq_bus = (dq_oe & dq_out) | (~dq_oe & m_oe & m_out) | (~dq_oe & ~m_oe & flt);
   always #25 mclk = ~mclk;
   always @(posedge mclk) flt <= ~flt;

   task automatic check_val(input string nm, input logic [20:0] exp, input logic [20:0] got);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : check_val

   task automatic set_req(input logic [2:0] op, input logic bm, input logic [20:0] a,
                          input logic [15:0] d);
      int n;
      n = 0;
      @(negedge mclk);
      while (req_ready !== 1'b1 && n < 100)
      begin
         @(negedge mclk);
         n++;
      end
      {req_op, req_byte_mode, req_addr, req_wdata, req_valid} = {op, bm, a, d, 1'b1};
      @(negedge mclk);
      req_valid = 1'b0;
   endtask : set_req

   task automatic do_op(input logic [2:0] op, input logic bm, input logic [20:0] a,
                        input logic [15:0] d);
      int n;
      n = 0;
      set_req(op, bm, a, d);
      while (rsp_valid !== 1'b1 && n < 200)
      begin
         @(negedge mclk);
         n++;
      end
      check_val("rsp_valid", 21'h1, {20'h0, rsp_valid});
   endtask : do_op

   task automatic finish_test();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   initial
   begin
      #200000;
      miscompares++;
      finish_test();
   end

   initial
   begin
      repeat (6) @(negedge mclk);
      rst_n = 1'b1;
      foreach (rows[i])
      begin
         r = rows[i];
         do_op(r.op, r.bm, r.a, r.d);
         w = u_fbo_flash_model.arr_word(r.bm ? r.a[20:1] : r.a[19:0]);
         ed = r.bm ? {8'h00, r.a[0] ? w[15:8] : w[7:0]} : w;
         if (r.op == 3'h0)
            check_val("read data", {5'h0, ed}, {5'h0, rsp_rdata});
         else
         begin
            check_val("latched addr", r.ea, u_fbo_flash_model.cmd_addr);
            check_val("latched data", {5'h0, r.ed}, {5'h0, u_fbo_flash_model.cmd_data});
            check_val("id level", {20'h0, r.op >= 3'h2}, {20'h0, u_fbo_flash_model.cmd_prot});
         end
      end
      do_op(3'h4, 1'b0, 21'h00_0000, 16'h0000);
      check_val("mode after reset", 21'h0, {20'h0, u_fbo_flash_model.mode_cmd});
      check_val("dev_ready", 21'h1, {20'h0, dev_ready});
      do_op(3'h0, 1'b0, 21'h00_0777, 16'h0000);
      w = u_fbo_flash_model.arr_word(20'h0_0777);
      check_val("read after reset", {5'h0, w}, {5'h0, rsp_rdata});
      set_req(3'h1, 1'b0, 21'h00_0123, 16'h1234);
      rst_n = 1'b0;
      @(negedge mclk);
      check_val("pins in reset", 21'h00_000B, {17'h0, ce_n, reset_n, dq_oe == 16'h0, req_ready});
      rst_n = 1'b1;
      do_op(3'h0, 1'b1, 21'h00_0777, 16'h0000);
      w = u_fbo_flash_model.arr_word(20'h0_03BB);
      check_val("byte read", {13'h0, w[15:8]}, {5'h0, rsp_rdata});
      repeat (3) @(negedge mclk);
      check_val("standby", 21'h1, {20'h0, ce_n && reset_n && dq_oe[14:0] == 15'h0 && m_oe == 16'h0});
      finish_test();
   end
endmodule : test_fbo_host
